// >>> hscl_board.sv
// board strap ties for the strap capture block
module hscl_board (
  input wire logic mclk, // clock
  input wire logic traffic, // pins in data use
  input wire logic [4:0] dp_set, // d+ ties
  input wire logic [4:0] dm_set, // d- ties
  output logic [4:0] dp, // d+ pins
  output logic [4:0] dm // d- pins
);
  logic [4:0] cnt = 5'h00;
  always @(posedge mclk) cnt <= cnt + 5'h01;
  // shared pins carry data once latched
  assign dp = traffic ? cnt : dp_set;
  assign dm = traffic ? ~cnt : dm_set;
endmodule // hscl_board

// >>> hscl_chk_assertions.sv
// checker for the strap capture block
module hscl_chk (
  input wire logic mclk, // clock
  input wire logic resetn, // reset
  input wire logic ext_resetn, // reset pin
  input wire logic [4:0] port_dplus_disable_strap, // pins
  input wire logic [2:0] fixed_port_count_strap, // code
  input wire logic [2:0] charging_port_count_strap, // code
  input wire logic [2:0] mode_strap2_level, // code
  input wire logic [2:0] mode_strap1_level, // code
  input wire logic [4:0] dplus_disabled, // out
  input wire logic [4:0] dminus_disabled, // out
  input wire logic [4:0] port2_disabled, // out
  input wire logic [4:0] port3_disabled, // out
  input wire logic [4:0] non_removable, // out
  input wire logic [4:0] charging_enabled, // out
  input wire hscl_pkg::hscl_mode_e op_mode, // out
  input wire logic config_valid // out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // own decode, reserved codes give no ports
  function automatic logic [4:0] thermo(input logic [2:0] c);
    return (c > 3'h5) ? 5'h00 : 5'h1f >> (3'h5 - c);
  endfunction
  sequence first_cap; !config_valid ##1 config_valid; endsequence
  sequence ext_cap; $rose(ext_resetn) ##2 1'b1; endsequence
  both_dis_a: assert property (port2_disabled == (dplus_disabled & dminus_disabled))
    else $error("port off without both straps");
  u3_follow_a: assert property (port3_disabled == port2_disabled)
    else $error("usb3 side differs");
  fixed_dec_a: assert property (first_cap |-> non_removable == thermo($past(fixed_port_count_strap)))
    else $error("fixed mask wrong");
  charge_dec_a: assert property (first_cap |-> charging_enabled == thermo($past(charging_port_count_strap)))
    else $error("charging mask wrong");
  mode_dec_a: assert property (first_cap |-> (op_mode == hscl_pkg::HSCL_MODE_CONFIG3) ==
    ($past(mode_strap2_level) == 3'h0 && $past(mode_strap1_level) == 3'h2)) else $error("mode wrong");
  por_cap_a: assert property (first_cap |-> dplus_disabled == $past(port_dplus_disable_strap))
    else $error("reset capture wrong");
  ext_cap_a: assert property (ext_cap |=> dplus_disabled == $past(port_dplus_disable_strap))
    else $error("pin capture wrong");
  hold_a: assert property ($changed(dplus_disabled) && $past(config_valid) |->
    $past(ext_resetn, 3) && !$past(ext_resetn, 4)) else $error("change off capture");
endmodule // hscl_chk

bind hscl_strap_latch hscl_chk chk_u (.*);

// >>> hscl_defs.svh
// constants for the strap capture block
`ifndef HSCL_DEFS_SVH
`define HSCL_DEFS_SVH

`define HSCL_PORTS 5
`define HSCL_LVL_W 3
// ------------------------------------------------------------
// level codes
// ------------------------------------------------------------
`define HSCL_LVL_WEAK_DN 3'h0
`define HSCL_LVL_WEAK_UP 3'h1
`define HSCL_LVL_MED_DN 3'h2
`define HSCL_LVL_MED_UP 3'h3
`define HSCL_LVL_STR_DN 3'h4
`define HSCL_LVL_STR_UP 3'h5
// ------------------------------------------------------------
// port masks by count
// ------------------------------------------------------------
`define HSCL_MASK_0 5'h00
`define HSCL_MASK_1 5'h01
`define HSCL_MASK_2 5'h03
`define HSCL_MASK_3 5'h07
`define HSCL_MASK_4 5'h0f
`define HSCL_MASK_5 5'h1f
// reset values of captured straps
`define HSCL_RST_PORTS 5'h00
`define HSCL_RST_LVL 3'h0

`endif

// >>> hscl_pkg.sv
// types for the strap capture block
package hscl_pkg;
  typedef enum logic [1:0] {
    HSCL_MODE_UNSUPPORTED = 2'b00,
    HSCL_MODE_CONFIG3 = 2'b01
  } hscl_mode_e;

  typedef enum logic [1:0] {
    HSCL_ST_RESET = 2'b00,
    HSCL_ST_LOAD = 2'b01,
    HSCL_ST_HOLD = 2'b10
  } hscl_state_e;

  typedef struct packed {
    hscl_state_e state;
    logic ext_sync1;
    logic ext_sync2;
    logic ext_prev;
    logic [4:0] dplus_cap;
    logic [4:0] dminus_cap;
    logic [2:0] fixed_cap;
    logic [2:0] charge_cap;
    logic [2:0] mode_cap;
    logic [2:0] mode2_cap;
    logic [2:0] mode1_cap;
    logic valid;
  } hscl_state_s;
endpackage

// >>> hscl_strap_latch.sv
// strap capture and decode for hub default configuration
`include "hscl_defs.svh"

module hscl_strap_latch (
  input wire logic mclk, // 10 MHz system clock
  input wire logic resetn, // power-on reset, async active low
  input wire logic ext_resetn, // external chip reset pin, active low
  input wire logic [4:0] port_dplus_disable_strap, // d+ disable strap pins, bit0 = port 1
  input wire logic [4:0] port_dminus_disable_strap, // d- disable strap pins, bit0 = port 1
  input wire logic [2:0] fixed_port_count_strap, // level code of non-removable strap
  input wire logic [2:0] charging_port_count_strap, // level code of charging strap
  input wire logic [2:0] mode_strap, // mode straps 3..1 as digital levels
  input wire logic [2:0] mode_strap2_level, // level code of mode strap 2
  input wire logic [2:0] mode_strap1_level, // level code of mode strap 1
  output logic [4:0] dplus_disabled, // per-port d+ disabled
  output logic [4:0] dminus_disabled, // per-port d- disabled
  output logic [4:0] port2_disabled, // per-port usb 2.0 disabled
  output logic [4:0] port3_disabled, // per-port usb 3.0 disabled
  output logic [4:0] non_removable, // per-port non-removable
  output logic [4:0] charging_enabled, // per-port battery charging enabled
  output logic [2:0] mode_straps, // captured mode straps 3..1
  output hscl_pkg::hscl_mode_e op_mode, // decoded operating mode
  output logic config_valid // high once straps are captured
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // six-level ladder to thermometer port mask; reserved codes give none
  function automatic logic [4:0] ladder_mask(input logic [2:0] lvl);
    logic [4:0] m;
    m = `HSCL_MASK_0;
    unique case (lvl)
      `HSCL_LVL_WEAK_DN: m = `HSCL_MASK_0;
      `HSCL_LVL_WEAK_UP: m = `HSCL_MASK_1;
      `HSCL_LVL_MED_DN: m = `HSCL_MASK_2;
      `HSCL_LVL_MED_UP: m = `HSCL_MASK_3;
      `HSCL_LVL_STR_DN: m = `HSCL_MASK_4;
      `HSCL_LVL_STR_UP: m = `HSCL_MASK_5;
      default: m = `HSCL_MASK_0;
    endcase
    return m;
  endfunction

  hscl_pkg::hscl_state_s s_r;
  hscl_pkg::hscl_state_s s_nxt;
  logic load;

  // ------------------------------------------------------------
  // capture control
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    load = 1'b0;
    s_nxt.ext_sync1 = ext_resetn;
    s_nxt.ext_sync2 = s_r.ext_sync1;
    s_nxt.ext_prev = s_r.ext_sync2;
    unique case (s_r.state)
      hscl_pkg::HSCL_ST_RESET: begin
        // first cycle after power-on release: nothing sampled yet, pins sampled next cycle in LOAD, never under async reset
        s_nxt.state = hscl_pkg::HSCL_ST_LOAD;
      end
      hscl_pkg::HSCL_ST_LOAD: begin
        load = 1'b1;
        s_nxt.state = hscl_pkg::HSCL_ST_HOLD;
      end
      hscl_pkg::HSCL_ST_HOLD: begin
        if (s_r.ext_sync2 && !s_r.ext_prev) begin
          load = 1'b1;
        end
      end
      default: s_nxt.state = hscl_pkg::HSCL_ST_RESET;
    endcase
    // straps settle long before release, so no synchroniser on them
    if (load) begin
      s_nxt.dplus_cap = port_dplus_disable_strap;
      s_nxt.dminus_cap = port_dminus_disable_strap;
      s_nxt.fixed_cap = fixed_port_count_strap;
      s_nxt.charge_cap = charging_port_count_strap;
      s_nxt.mode_cap = mode_strap;
      s_nxt.mode2_cap = mode_strap2_level;
      s_nxt.mode1_cap = mode_strap1_level;
      s_nxt.valid = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      // sync chain resets to the idle pin level so no false rising edge follows reset
      s_r <= '{state: hscl_pkg::HSCL_ST_RESET, ext_sync1: 1'b1, ext_sync2: 1'b1, ext_prev: 1'b1,
               dplus_cap: `HSCL_RST_PORTS, dminus_cap: `HSCL_RST_PORTS, fixed_cap: `HSCL_RST_LVL,
               charge_cap: `HSCL_RST_LVL, mode_cap: `HSCL_RST_LVL, mode2_cap: `HSCL_RST_LVL,
               mode1_cap: `HSCL_RST_LVL, valid: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // decode of captured values
  // ------------------------------------------------------------
  always_comb begin
    dplus_disabled = s_r.dplus_cap;
    dminus_disabled = s_r.dminus_cap;
    port2_disabled = s_r.dplus_cap & s_r.dminus_cap;
    port3_disabled = s_r.dplus_cap & s_r.dminus_cap;
    non_removable = ladder_mask(s_r.fixed_cap);
    charging_enabled = ladder_mask(s_r.charge_cap);
    mode_straps = s_r.mode_cap;
    if (s_r.mode2_cap == `HSCL_LVL_WEAK_DN && s_r.mode1_cap == `HSCL_LVL_MED_DN) begin
      op_mode = hscl_pkg::HSCL_MODE_CONFIG3;
    end else begin
      op_mode = hscl_pkg::HSCL_MODE_UNSUPPORTED;
    end
    config_valid = s_r.valid;
  end

endmodule // hscl_strap_latch

// >>> hub_strap_config_latch_bench.sv
// testbench for the strap capture block
module hub_strap_config_latch_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, resetn = 1'b0, ext_resetn = 1'b1, traffic = 1'b0, valid;
  logic [4:0] dp_set, dm_set, dp, dm, dpo, dmo, p2o, p3o, nro, cho;
  logic [2:0] fix, chg, m2, m1, mstr, mso;
  hscl_pkg::hscl_mode_e mode;
  int bad_count = 0, check_count = 0, cyc = 0;
  logic [63:0] rows [8] = '{64'h01f1_f050_21f0_01f1, 64'h0151_f140_0150_10f0, 64'h00a1_b231_20a0_3070,
    64'h0001_f320_2000_7031, 64'h01f0_0412_0000_f010, 64'h0131_6505_2121_f000, 64'h0010_1670_3010_0000,
    64'h01e1_e760_21e0_0001};
  always #50 mclk = ~mclk;
  hscl_board board_u (.mclk(mclk), .traffic(traffic), .dp_set(dp_set), .dm_set(dm_set), .dp(dp), .dm(dm));
  hscl_strap_latch dut_u (.mclk(mclk), .resetn(resetn), .ext_resetn(ext_resetn), .port_dplus_disable_strap(dp),
    .port_dminus_disable_strap(dm), .fixed_port_count_strap(fix), .charging_port_count_strap(chg),
    .mode_strap(mstr), .mode_strap2_level(m2), .mode_strap1_level(m1), .dplus_disabled(dpo),
    .dminus_disabled(dmo), .port2_disabled(p2o), .port3_disabled(p3o), .non_removable(nro),
    .charging_enabled(cho), .mode_straps(mso), .op_mode(mode), .config_valid(valid));
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic apply(input logic [63:0] r);
    {dp_set, dm_set, fix, chg} <= {r[56:52], r[48:44], r[42:40], r[38:36]};
    {m2, m1, mstr} <= {r[34:32], r[30:28], r[30:28]};
  endtask
  task automatic verify(input logic [63:0] r);
    chk(dpo, r[56:52]);
    chk(dmo, r[48:44]);
    chk(p2o, r[24:20]);
    chk(p3o, r[24:20]);
    chk(nro, r[16:12]);
    chk(cho, r[8:4]);
    chk({mso, 1'b0, valid}, {r[30:28], 2'h1});
    chk({3'h0, mode}, {3'h0, r[1:0]});
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 1000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    apply(rows[0]);
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 verify(rows[0]);
    foreach (rows[i]) begin
      @(posedge mclk);
      apply(rows[i]);
      ext_resetn <= 1'b0;
      repeat (3) @(posedge mclk);
      ext_resetn <= 1'b1;
      repeat (5) @(posedge mclk);
      traffic <= 1'b1;
      repeat (4) @(posedge mclk);
      #1 verify(rows[i]);
      @(posedge mclk);
      traffic <= 1'b0;
    end
    // second reset mid-run must clear and recapture
    resetn <= 1'b0;
    apply(rows[5]);
    repeat (2) @(posedge mclk);
    #1 chk({valid, dpo[3:0]}, 5'h00);
    @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 verify(rows[5]);
    summarize();
  end
endmodule // hub_strap_config_latch_bench
